// >>> design/dibs_pkg.sv
package dibs_pkg;
    // ************************************************************
    // configuration modes
    // ************************************************************
    typedef enum logic [2:0] {
        DIBS_MODE_DUAL_COMP,
        DIBS_MODE_SINGLE_COMP,
        DIBS_MODE_SINGLE_COMP_MEM,
        DIBS_MODE_SINGLE_UNCOMP,
        DIBS_MODE_SINGLE_UNCOMP_MEM
    } dibs_mode_t;

    // ************************************************************
    // error causes and widths
    // ************************************************************
    typedef enum logic [1:0] {
        DIBS_ERR_NONE,
        DIBS_ERR_CRC,
        DIBS_ERR_WDOG
    } dibs_err_t;

    localparam int          DIBS_AW         = 16;
    localparam int          DIBS_DW         = 32;
    localparam logic [15:0] DIBS_ADDR_ZERO  = 16'h0000;
    localparam logic [15:0] DIBS_ADDR_ONE   = 16'h0001;
    localparam logic [31:0] DIBS_DATA_ZERO  = 32'h0000_0000;
    localparam logic        DIBS_IMAGE0     = 1'b0;
    localparam logic        DIBS_IMAGE1     = 1'b1;
    localparam logic [1:0]  DIBS_TRY_FIRST  = 2'h0;
    localparam logic [1:0]  DIBS_TRY_REVERT = 2'h1;
    localparam logic [1:0]  DIBS_TRY_STUCK  = 2'h2;
endpackage

// >>> design/dibs_copy_if.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// copy engine handshake between sequencer and copier
// ************************************************************
interface dibs_copy_if;
    import dibs_pkg::*;
    logic        start;
    logic        image;
    logic [15:0] length;
    logic        busy;
    logic        done;
    modport seq  (output start, output image, output length, input busy, input done);
    modport copy (input start, input image, input length, output busy, output done);
endinterface
`default_nettype wire

// >>> design/dibs_copier.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// config_flash to config_ram copier
// ************************************************************
module dibs_copier
    import dibs_pkg::*;
(
    // clock and reset
    input  wire logic                 REF_CLK,
    input  wire logic                 NRST,
    // control
    dibs_copy_if.copy                 cif,
    // config_flash read port
    output logic [dibs_pkg::DIBS_AW:0] FLASH_ADDR,
    output logic                       FLASH_RD,
    input  wire logic [dibs_pkg::DIBS_DW-1:0] FLASH_DATA,
    // config_ram write port
    output logic [dibs_pkg::DIBS_AW-1:0] RAM_ADDR,
    output logic [dibs_pkg::DIBS_DW-1:0] RAM_DATA,
    output logic                         RAM_WR
);
    logic                busy_reg, busy_next;
    logic                rd_reg, rd_next;
    logic                img_reg, img_next;
    logic [DIBS_AW-1:0]  idx_reg, idx_next;
    logic [DIBS_AW-1:0]  len_reg, len_next;
    logic [DIBS_AW-1:0]  waddr_reg, waddr_next;
    logic [DIBS_DW-1:0]  wdata_reg, wdata_next;
    logic                wr_reg, wr_next;
    logic                done_reg, done_next;

    // read flash word, write it to ram next cycle
    always_comb begin
        busy_next  = busy_reg;
        rd_next    = 1'b0;
        img_next   = img_reg;
        idx_next   = idx_reg;
        len_next   = len_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wr_next    = 1'b0;
        done_next  = 1'b0;
        if (rd_reg) begin
            wr_next    = 1'b1;
            waddr_next = idx_reg;
            wdata_next = FLASH_DATA;
            idx_next   = idx_reg + DIBS_ADDR_ONE;
        end
        if (!busy_reg && cif.start) begin
            busy_next = 1'b1;
            img_next  = cif.image;
            idx_next  = DIBS_ADDR_ZERO;
            len_next  = cif.length;
        end else if (busy_reg && !rd_reg) begin
            if (idx_reg == len_reg) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                rd_next = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            busy_reg  <= 1'b0;
            rd_reg    <= 1'b0;
            img_reg   <= DIBS_IMAGE0;
            idx_reg   <= DIBS_ADDR_ZERO;
            len_reg   <= DIBS_ADDR_ZERO;
            waddr_reg <= DIBS_ADDR_ZERO;
            wdata_reg <= DIBS_DATA_ZERO;
            wr_reg    <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            busy_reg  <= busy_next;
            rd_reg    <= rd_next;
            img_reg   <= img_next;
            idx_reg   <= idx_next;
            len_reg   <= len_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wr_reg    <= wr_next;
            done_reg  <= done_next;
        end
    end

    assign FLASH_ADDR = {img_reg, idx_reg};
    assign FLASH_RD   = rd_reg;
    assign RAM_ADDR   = waddr_reg;
    assign RAM_DATA   = wdata_reg;
    assign RAM_WR     = wr_reg;
    assign cif.busy   = busy_reg;
    assign cif.done   = done_reg;

    ram_follows_read_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        FLASH_RD |=> RAM_WR && RAM_DATA == $past(FLASH_DATA)) else $error("ram write missing after read");
endmodule
`default_nettype wire

// >>> design/dibs_top.sv
`timescale 1ns/1ns
`default_nettype none
module dibs_top
    import dibs_pkg::*;
(
    // clock and reset
    input  wire logic                          REF_CLK,
    input  wire logic                          NRST,
    // configuration options
    input  wire dibs_pkg::dibs_mode_t          CONFIG_MODE,
    input  wire logic                          FLASH_PROGRAMMED,
    input  wire logic                          AUTO_RECONFIG_EN,
    input  wire logic [dibs_pkg::DIBS_AW-1:0]  IMAGE_LENGTH,
    // image select
    input  wire logic                          IMAGE_SELECT_JUMPER,
    input  wire logic                          UPGRADE_IMAGE_WR,
    input  wire logic                          UPGRADE_IMAGE_VAL,
    // error sources
    input  wire logic                          CRC_ERROR,
    input  wire logic                          WDOG_TIMEOUT,
    // reconfiguration sources
    input  wire logic                          CONFIG_FAULT_LINE_N,
    input  wire logic                          RECONFIG_REQUEST_LINE_N,
    input  wire logic                          UPGRADE_RECONFIG_REQUEST_N,
    // config_flash
    output logic [dibs_pkg::DIBS_AW:0]         FLASH_ADDR,
    output logic                               FLASH_RD,
    input  wire logic [dibs_pkg::DIBS_DW-1:0]  FLASH_DATA,
    // config_ram
    output logic [dibs_pkg::DIBS_AW-1:0]       RAM_ADDR,
    output logic [dibs_pkg::DIBS_DW-1:0]       RAM_DATA,
    output logic                               RAM_WR,
    // status
    output logic                               USER_MODE,
    output logic                               WAITING,
    output logic                               ACTIVE_IMAGE,
    output logic                               FAILED_IMAGE,
    output dibs_pkg::dibs_err_t                ERROR_CAUSE
);
    // ************************************************************
    // sequencer state
    // ************************************************************
    typedef enum logic [2:0] {IDLE, SAMPLE, LOAD, USER, WAIT} dibs_state_t;

    dibs_state_t state_reg, state_next;
    logic        img_reg, img_next;
    logic        ovr_valid_reg, ovr_valid_next;
    logic        ovr_img_reg, ovr_img_next;
    logic [1:0]  try_reg, try_next;
    logic        fail_img_reg, fail_img_next;
    dibs_err_t   cause_reg, cause_next;
    logic        start_reg, start_next;
    logic        reconfig;
    logic        err;
    dibs_err_t   err_kind;

    dibs_copy_if cif ();

    dibs_copier u_copier (
        .REF_CLK    (REF_CLK),
        .NRST       (NRST),
        .cif        (cif),
        .FLASH_ADDR (FLASH_ADDR),
        .FLASH_RD   (FLASH_RD),
        .FLASH_DATA (FLASH_DATA),
        .RAM_ADDR   (RAM_ADDR),
        .RAM_DATA   (RAM_DATA),
        .RAM_WR     (RAM_WR)
    );

    assign reconfig = !CONFIG_FAULT_LINE_N || !RECONFIG_REQUEST_LINE_N
                   || !UPGRADE_RECONFIG_REQUEST_N;
    assign err      = CRC_ERROR || WDOG_TIMEOUT;
    assign err_kind = CRC_ERROR ? DIBS_ERR_CRC : DIBS_ERR_WDOG;

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        state_next     = state_reg;
        img_next       = img_reg;
        ovr_valid_next = ovr_valid_reg;
        ovr_img_next   = ovr_img_reg;
        try_next       = try_reg;
        fail_img_next  = fail_img_reg;
        cause_next     = cause_reg;
        start_next     = 1'b0;
        if (UPGRADE_IMAGE_WR) begin
            ovr_valid_next = 1'b1;
            ovr_img_next   = UPGRADE_IMAGE_VAL;
        end
        unique case (state_reg)
            IDLE: begin
                if (FLASH_PROGRAMMED) begin
                    state_next = SAMPLE;
                end
            end
            SAMPLE: begin
                // single-image modes always use image0
                if (CONFIG_MODE != DIBS_MODE_DUAL_COMP) begin
                    img_next = DIBS_IMAGE0;
                end else if (ovr_valid_reg) begin
                    img_next = ovr_img_reg;
                end else begin
                    img_next = IMAGE_SELECT_JUMPER;
                end
                try_next   = DIBS_TRY_FIRST;
                cause_next = DIBS_ERR_NONE;
                start_next = 1'b1;
                state_next = LOAD;
            end
            LOAD: begin
                // copy errors ignored until user mode
                if (cif.done) begin
                    state_next = USER;
                end
            end
            USER: begin
                if (reconfig) begin
                    state_next = SAMPLE;
                end else if (err) begin
                    fail_img_next = img_reg;
                    cause_next    = err_kind;
                    if (try_reg == DIBS_TRY_FIRST && CONFIG_MODE == DIBS_MODE_DUAL_COMP) begin
                        img_next   = ~img_reg;
                        try_next   = DIBS_TRY_REVERT;
                        start_next = 1'b1;
                        state_next = LOAD;
                    end else if (AUTO_RECONFIG_EN) begin
                        state_next = SAMPLE;
                    end else begin
                        try_next   = DIBS_TRY_STUCK;
                        state_next = WAIT;
                    end
                end
            end
            WAIT: begin
                if (reconfig) begin
                    state_next = SAMPLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg     <= IDLE;
            img_reg       <= DIBS_IMAGE0;
            ovr_valid_reg <= 1'b0;
            ovr_img_reg   <= DIBS_IMAGE0;
            try_reg       <= DIBS_TRY_FIRST;
            fail_img_reg  <= DIBS_IMAGE0;
            cause_reg     <= DIBS_ERR_NONE;
            start_reg     <= 1'b0;
        end else begin
            state_reg     <= state_next;
            img_reg       <= img_next;
            ovr_valid_reg <= ovr_valid_next;
            ovr_img_reg   <= ovr_img_next;
            try_reg       <= try_next;
            fail_img_reg  <= fail_img_next;
            cause_reg     <= cause_next;
            start_reg     <= start_next;
        end
    end

    assign cif.start    = start_reg;
    assign cif.image    = img_reg;
    assign cif.length   = IMAGE_LENGTH;
    assign USER_MODE    = (state_reg == USER);
    assign WAITING      = (state_reg == WAIT);
    assign ACTIVE_IMAGE = img_reg;
    assign FAILED_IMAGE = fail_img_reg;
    assign ERROR_CAUSE  = cause_reg;

    // ************************************************************
    // checks
    // ************************************************************
    sequence first_run_err_s;
        USER_MODE && try_reg == DIBS_TRY_FIRST && !reconfig && err
            && CONFIG_MODE == DIBS_MODE_DUAL_COMP;
    endsequence

    revert_other_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        first_run_err_s |=> ACTIVE_IMAGE != $past(ACTIVE_IMAGE) && FAILED_IMAGE == $past(ACTIVE_IMAGE))
        else $error("no revert to other image");
    cause_latched_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        USER_MODE && err && !reconfig |=> ERROR_CAUSE == ($past(CRC_ERROR) ? DIBS_ERR_CRC : DIBS_ERR_WDOG))
        else $error("error cause wrong");
    second_err_wait_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        USER_MODE && try_reg != DIBS_TRY_FIRST && err && !reconfig && !AUTO_RECONFIG_EN |=> WAITING)
        else $error("no wait after second error");
    auto_reconf_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        USER_MODE && try_reg != DIBS_TRY_FIRST && err && !reconfig && AUTO_RECONFIG_EN
        |=> state_reg == SAMPLE ##1 cif.start) else $error("auto reconfig missing");
    wait_exit_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WAITING && reconfig |=> state_reg == SAMPLE) else $error("reconfig ignored");
    wait_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        WAITING && !reconfig |=> WAITING && $stable(ERROR_CAUSE) && $stable(FAILED_IMAGE))
        else $error("state left wait alone");
    pin_select_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        state_reg == SAMPLE && !ovr_valid_reg && CONFIG_MODE == DIBS_MODE_DUAL_COMP
        |=> ACTIVE_IMAGE == $past(IMAGE_SELECT_JUMPER)) else $error("pin select wrong");
    override_sel_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        state_reg == SAMPLE && ovr_valid_reg && CONFIG_MODE == DIBS_MODE_DUAL_COMP
        |=> ACTIVE_IMAGE == $past(ovr_img_reg)) else $error("override ignored");
    no_load_early_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        state_reg == IDLE |-> !cif.start && !FLASH_RD) else $error("load before programmed");
    single_img0_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        state_reg == SAMPLE && CONFIG_MODE != DIBS_MODE_DUAL_COMP |=> ACTIVE_IMAGE == DIBS_IMAGE0)
        else $error("single mode image wrong");
    copy_idle_start_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        cif.start |-> !cif.busy) else $error("copy started while busy");
endmodule
`default_nettype wire

// >>> sim/dibs_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// config_flash holding image0 and image1
// ************************************************************
module dibs_flash_model
    import dibs_pkg::*;
(
    // clock
    input  wire logic                         REF_CLK,
    // read port
    input  wire logic [dibs_pkg::DIBS_AW:0]   FLASH_ADDR,
    input  wire logic                         FLASH_RD,
    output logic      [dibs_pkg::DIBS_DW-1:0] FLASH_DATA
);
    logic [31:0] last_reg = 32'h0000_0000;

    always @(posedge REF_CLK) begin
        last_reg <= FLASH_DATA;
    end

    // image tag, fixed byte, word index; garbage outside the read cycle
    always_comb begin
        if (FLASH_RD) begin
            FLASH_DATA = {(FLASH_ADDR[16] ? 8'hB1 : 8'h0E), 8'h3C, FLASH_ADDR[15:0]};
        end else begin
            FLASH_DATA = ~last_reg;
        end
    end
endmodule
`default_nettype wire

// >>> sim/dibs_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dibs_top_bench;
    import dibs_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    dibs_mode_t  mode = DIBS_MODE_DUAL_COMP;
    logic        programmed = 1'b0;
    logic        auto_en = 1'b0;
    logic [15:0] img_len = 16'h0000;
    logic        jumper = 1'b1;
    logic        upg_wr = 1'b0;
    logic        upg_val = 1'b0;
    logic        crc_err = 1'b0;
    logic        wdog = 1'b0;
    logic        fault_n = 1'b1;
    logic        req_n = 1'b1;
    logic        upg_req_n = 1'b1;
    logic [16:0] flash_addr;
    logic        flash_rd;
    logic [31:0] flash_data;
    logic [15:0] ram_addr;
    logic [31:0] ram_data;
    logic        ram_wr;
    logic        user_mode;
    logic        waiting;
    logic        act_img;
    logic        fail_img;
    dibs_err_t   err_cause;
    int          bad_count = 0;
    int          check_count = 0;
    logic [47:0] exp_q[$];
    logic [15:0] len;

    always #20 ref_clk = ~ref_clk;

    dibs_top i_dut (.REF_CLK(ref_clk), .NRST(nrst), .CONFIG_MODE(mode), .FLASH_PROGRAMMED(programmed),
        .AUTO_RECONFIG_EN(auto_en), .IMAGE_LENGTH(img_len), .IMAGE_SELECT_JUMPER(jumper),
        .UPGRADE_IMAGE_WR(upg_wr), .UPGRADE_IMAGE_VAL(upg_val), .CRC_ERROR(crc_err), .WDOG_TIMEOUT(wdog),
        .CONFIG_FAULT_LINE_N(fault_n), .RECONFIG_REQUEST_LINE_N(req_n),
        .UPGRADE_RECONFIG_REQUEST_N(upg_req_n), .FLASH_ADDR(flash_addr), .FLASH_RD(flash_rd),
        .FLASH_DATA(flash_data), .RAM_ADDR(ram_addr), .RAM_DATA(ram_data), .RAM_WR(ram_wr),
        .USER_MODE(user_mode), .WAITING(waiting), .ACTIVE_IMAGE(act_img), .FAILED_IMAGE(fail_img),
        .ERROR_CAUSE(err_cause));

    dibs_flash_model i_flash (.REF_CLK(ref_clk), .FLASH_ADDR(flash_addr), .FLASH_RD(flash_rd),
        .FLASH_DATA(flash_data));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // note the words of one image copy and set its length
    task automatic load(input logic img, input logic [15:0] n);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back({i[15:0], (img ? 8'hB1 : 8'h0E), 8'h3C, i[15:0]});
        end
        img_len <= n;
    endtask

    // wait for user mode, then check status; x skips a field
    task automatic settle(input logic img, input logic fimg, input logic [1:0] cause);
        int n;
        n = 0;
        while (user_mode !== 1'b1 && n < 500) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 500) begin
            bad_count++;
            close_out();
        end
        check(48'(exp_q.size()), 48'h0);
        check(48'(act_img), 48'(img));
        if (fimg !== 1'bx) check(48'(fail_img), 48'(fimg));
        if (cause !== 2'bxx) check(48'(err_cause), 48'(cause));
        tick(1);
    endtask

    // one-cycle pulse on the chosen error or reconfig source
    task automatic hit(input int src);
        crc_err <= (src == 0);
        wdog <= (src == 1);
        fault_n <= (src != 2);
        req_n <= (src != 3);
        upg_req_n <= (src != 4);
        tick(1);
        crc_err <= 1'b0;
        wdog <= 1'b0;
        fault_n <= 1'b1;
        req_n <= 1'b1;
        upg_req_n <= 1'b1;
        tick(2);
    endtask

    // ************************************************************
    // config_ram write monitor
    // ************************************************************
    always @(negedge ref_clk) begin
        if (ram_wr === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({ram_addr, ram_data}, 48'hX);
            end else begin
                check({ram_addr, ram_data}, exp_q.pop_front());
            end
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h88bf));
        tick(4);
        nrst <= 1'b1;
        tick(10);
        check(48'(flash_rd), 48'h0);
        load(1'b1, 16'h0004);
        programmed <= 1'b1;
        tick(2);
        settle(1'b1, 1'b0, DIBS_ERR_NONE);
        load(1'b0, 16'h0005);
        hit(0);
        settle(1'b0, 1'b1, DIBS_ERR_CRC);
        tick(20);
        check({act_img, fail_img, err_cause}, {1'b0, 1'b1, DIBS_ERR_CRC});
        hit(1);
        tick(10);
        check(48'(waiting), 48'h1);
        check({fail_img, err_cause}, {1'b0, DIBS_ERR_WDOG});
        jumper <= 1'b0;
        upg_val <= 1'b1;
        upg_wr <= 1'b1;
        tick(1);
        upg_wr <= 1'b0;
        for (int s = 2; s < 5; s++) begin
            len = 16'($urandom_range(1, 6));
            load(1'b1, len);
            hit(s);
            settle(1'b1, 1'bx, DIBS_ERR_NONE);
        end
        jumper <= 1'b1;
        for (int m = 1; m < 5; m++) begin
            nrst <= 1'b0;
            mode <= dibs_mode_t'(m);
            tick(4);
            load(1'b0, 16'h0003);
            nrst <= 1'b1;
            tick(2);
            settle(1'b0, 1'b0, DIBS_ERR_NONE);
        end
        mode <= DIBS_MODE_DUAL_COMP;
        auto_en <= 1'b1;
        load(1'b1, 16'h0002);
        hit(3);
        settle(1'b1, 1'b0, DIBS_ERR_NONE);
        load(1'b0, 16'h0002);
        hit(0);
        settle(1'b0, 1'b1, DIBS_ERR_CRC);
        load(1'b1, 16'h0002);
        hit(1);
        check(48'(waiting), 48'h0);
        settle(1'b1, 1'b0, DIBS_ERR_NONE);
        close_out();
    end
endmodule
`default_nettype wire
